// file: drive_limit_pkg.sv
// Purpose: Shared constants, types and helpers for the drive limit block
// Assumes: Frequency in 0.1 Hz, current in 0.1 A, feedback in 0.001 units
// Notes:   Feedback values are two's complement, 32 bits
package drive_limit_pkg;

  localparam int FREQ_W = 16;
  localparam int CUR_W  = 16;
  localparam int FB_W   = 32;
  localparam int NWARN  = 6;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_ROUTE    = 8'h04;
  localparam logic [7:0] OFS_CUR_LO   = 8'h08;
  localparam logic [7:0] OFS_CUR_HI   = 8'h0C;
  localparam logic [7:0] OFS_FRQ_LO   = 8'h10;
  localparam logic [7:0] OFS_FRQ_HI   = 8'h14;
  localparam logic [7:0] OFS_FB_LO    = 8'h18;
  localparam logic [7:0] OFS_FB_HI    = 8'h1C;
  localparam logic [7:0] OFS_BYP_BW   = 8'h20;
  localparam logic [7:0] OFS_BYP_F1   = 8'h24;
  localparam logic [7:0] OFS_BYP_F2   = 8'h28;
  localparam logic [7:0] OFS_STATUS   = 8'h2C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h34;

  // Field positions
  localparam int ROUTE_RELAY_LSB = 8;
  localparam int STATUS_ARM_BIT  = 8;

  // Limits and reset values
  localparam logic [FREQ_W-1:0] FRQ_MAX_NARROW = 16'h0528; // 132.0 Hz
  localparam logic [FREQ_W-1:0] FRQ_MAX_WIDE   = 16'h2710; // 1000.0 Hz
  localparam logic [FREQ_W-1:0] FRQ_HI_RST     = 16'h0528; // 132.0 Hz
  localparam logic [FREQ_W-1:0] BYP_BW_MAX     = 16'h03E8; // 100.0 Hz
  localparam logic [FREQ_W-1:0] BYP_F_MAX      = 16'h2710; // 1000.0 Hz
  localparam logic [FB_W-1:0]   FEEDBACK_RANGE_MIN_LIM     = 32'hFA0A_1F00; // -100000.000
  localparam logic [FB_W-1:0]   FEEDBACK_RANGE_MAX_LIM     = 32'h05F5_E100; // 100000.000
  localparam logic [FB_W-1:0]   FB_LO_RST      = 32'hFFC2_F700; // -4000.000
  localparam logic [FB_W-1:0]   FB_HI_RST      = 32'h003D_0900; // 4000.000
  localparam logic [1:0]        RANGE_WIDE_MIN = 2'h2;

  typedef enum logic [1:0] {ST_STOPPED, ST_RAMPING, ST_ARMED} arm_state_t;

  // Measured drive quantities
  typedef struct packed {
    logic                run;
    logic [CUR_W-1:0]    current;
    logic [FREQ_W-1:0]   out_freq;
    logic [FREQ_W-1:0]   ref_freq;
    logic [FREQ_W-1:0]   demand_freq;
    logic [FB_W-1:0]     feedback;
  } drive_meas_t;

  // Byte-lane merge of a write
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Unsigned clamp
  function automatic logic [31:0] clamp_u(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Signed values mapped to unsigned order
  function automatic logic [31:0] s2u(input logic [31:0] v);
    return {~v[31], v[30:0]};
  endfunction

  // Move a frequency out of one avoided band to its nearest edge
  function automatic logic [FREQ_W-1:0] avoid(input logic [FREQ_W-1:0] f,
                                              input logic [FREQ_W-1:0] c,
                                              input logic [FREQ_W-1:0] bw);
    logic [FREQ_W-1:0] half;
    logic [FREQ_W-1:0] lo;
    logic [FREQ_W:0]   hi;
    half = bw >> 1;
    lo   = (c > half) ? c - half : '0;
    hi   = {1'b0, c} + {1'b0, half};
    if (bw == '0 || f < lo || {1'b0, f} > hi) begin
      return f;
    end
    if (f < c) begin
      return lo;
    end
    return hi[FREQ_W] ? '1 : hi[FREQ_W-1:0];
  endfunction

endpackage

// file: limit_window.sv
// Purpose: Window comparator, flags a value below or above its limits
// Assumes: Unsigned operands; signed ones are pre-mapped by the caller
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module limit_window #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] value_i,
  input  wire logic [W-1:0] lo_i,
  input  wire logic [W-1:0] hi_i,
  output logic              below_o,
  output logic              above_o
);

  if (W < 1) begin : g_chk
    $error("limit_window: W must be at least 1");
  end

  // Strict comparisons against both limits
  assign below_o = value_i < lo_i;
  assign above_o = value_i > hi_i;

endmodule // limit_window
`default_nettype wire

// file: drive_limit_warning_and_bypass.sv
// Purpose: Limit warnings, warning routing and frequency bypass of a drive
// Assumes: Classic Wishbone slave, one clock, synchronous reset
// Notes:   Warnings are blanked until output frequency meets reference
//
// Overview of operation
// - Warn high current when output current exceeds upper current limit.
// - Warn low current when current is below lower limit, default zero.
// - Warn low frequency when output frequency is below lower limit.
// - Warn high frequency when output frequency exceeds upper limit.
// - Warn low feedback when feedback is below lower feedback limit.
// - Warn high feedback when feedback exceeds upper feedback limit.
// - Suppress all warnings during ramp-up, after stop, and while stopped.
// - Arm comparators once output frequency reaches the resulting reference.
// - Any warning may be routed to digital output and relay.
// - Upper frequency limit spans lower limit to 132 or 1000 Hz by range.
// - Upper feedback limit spans lower limit to 100000, default 4000.
// - Bypass bandwidth spans 0 to 100 Hz; zero disables bypass.
// - Bandwidth is centred on each bypass frequency to form bands.
// - Two bypass frequencies, each 0 to 1000 Hz, default 0 Hz.
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module drive_limit_warning_and_bypass
  import drive_limit_pkg::*;
#(
  parameter logic [CUR_W-1:0] CUR_HI_RST = 16'hFFFF
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              run_i,
  input  wire logic [CUR_W-1:0]  current_i,
  input  wire logic [FREQ_W-1:0] out_freq_i,
  input  wire logic [FREQ_W-1:0] ref_freq_i,
  input  wire logic [FREQ_W-1:0] demand_freq_i,
  input  wire logic [FB_W-1:0]   feedback_i,
  output logic [NWARN-1:0]       warn_o,
  output logic                   digital_out_o,
  output logic                   relay_o,
  output logic [FREQ_W-1:0]      bypass_freq_o,
  output logic                   irq_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Register words hold limits of up to 16 bits and 32-bit feedback
  if (CUR_W > 16 || FREQ_W > 16 || FB_W != 32) begin : g_width_chk
    $error("drive_limit_warning_and_bypass: unsupported field widths");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Arming and range select
    arm_state_t          arm;
    logic                run_q;
    logic [1:0]          freq_range;
    // Warning routing masks
    logic [NWARN-1:0]    route_dout;
    logic [NWARN-1:0]    route_relay;
    // Programmed window limits
    logic [CUR_W-1:0]    cur_lo;
    logic [CUR_W-1:0]    cur_hi;
    logic [FREQ_W-1:0]   frq_lo;
    logic [FREQ_W-1:0]   frq_hi;
    logic [FB_W-1:0]     fb_lo;
    logic [FB_W-1:0]     fb_hi;
    // Avoided bands
    logic [FREQ_W-1:0]   byp_bw;
    logic [FREQ_W-1:0]   byp_f1;
    logic [FREQ_W-1:0]   byp_f2;
    // Warnings and interrupt
    logic [NWARN-1:0]    warn;
    logic [NWARN-1:0]    irq_stat;
    logic [NWARN-1:0]    irq_mask;
    logic                irq;
    // Registered outputs and bus answer
    logic                dout;
    logic                relay;
    logic [FREQ_W-1:0]   byp_out;
    logic                ack;
    logic [31:0]         rdat;
  } state_t;

  state_t      st_r;
  state_t      st_nxt;
  drive_meas_t meas;

  logic cur_below;
  logic cur_above;
  logic frq_below;
  logic frq_above;
  logic fb_below;
  logic fb_above;

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // Gather drive inputs
  assign meas = '{run: run_i, current: current_i, out_freq: out_freq_i,
                  ref_freq: ref_freq_i, demand_freq: demand_freq_i,
                  feedback: feedback_i};

  // Output current window
  limit_window #(.W(CUR_W)) u_cur (
    .value_i (meas.current),
    .lo_i    (st_r.cur_lo),
    .hi_i    (st_r.cur_hi),
    .below_o (cur_below),
    .above_o (cur_above)
  );

  // Output frequency window
  limit_window #(.W(FREQ_W)) u_frq (
    .value_i (meas.out_freq),
    .lo_i    (st_r.frq_lo),
    .hi_i    (st_r.frq_hi),
    .below_o (frq_below),
    .above_o (frq_above)
  );

  // Feedback is signed; compare in offset order
  limit_window #(.W(FB_W)) u_fb (
    .value_i (s2u(meas.feedback)),
    .lo_i    (s2u(st_r.fb_lo)),
    .hi_i    (s2u(st_r.fb_hi)),
    .below_o (fb_below),
    .above_o (fb_above)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic              req;
    logic              wr;
    logic [31:0]       cur;
    logic [31:0]       mrg;
    logic [FREQ_W-1:0] fmax;
    logic [NWARN-1:0]  wnxt;
    logic [NWARN-1:0]  clr;
    logic [FREQ_W-1:0] f;
    // A request is taken only while no answer stands
    req    = wb_cyc_i && wb_stb_i && !st_r.ack;
    wr     = req && wb_we_i;
    cur    = '0;
    mrg    = '0;
    fmax   = '0;
    wnxt   = '0;
    clr    = '0;
    f      = '0;
    st_nxt = st_r;

    // Arming sequence: stop blanks, ramp waits for reference
    st_nxt.run_q = meas.run;
    unique case (st_r.arm)
      // Idle until a start command
      ST_STOPPED: begin
        if (meas.run) begin
          st_nxt.arm = ST_RAMPING;
        end
      end
      // Blanked until output meets reference
      ST_RAMPING: begin
        if (!meas.run) begin
          st_nxt.arm = ST_STOPPED;
        end else if (meas.out_freq == meas.ref_freq) begin
          st_nxt.arm = ST_ARMED;
        end
      end
      // Comparators live until stop
      ST_ARMED: begin
        if (!meas.run) begin
          st_nxt.arm = ST_STOPPED;
        end else if (!st_r.run_q) begin
          st_nxt.arm = ST_RAMPING;
        end
      end
    endcase

    // Warnings only while armed
    if (st_r.arm == ST_ARMED && meas.run) begin
      wnxt[0] = cur_above;
      wnxt[1] = cur_below;
      wnxt[2] = frq_below;
      wnxt[3] = frq_above;
      wnxt[4] = fb_below;
      wnxt[5] = fb_above;
    end
    // Routed outputs follow the same warning word
    st_nxt.warn  = wnxt;
    st_nxt.dout  = |(wnxt & st_r.route_dout);
    st_nxt.relay = |(wnxt & st_r.route_relay);

    // Frequency bypass through both bands
    f = avoid(meas.demand_freq, st_r.byp_f1, st_r.byp_bw);
    // Band two acts on the result of band one
    f = avoid(f, st_r.byp_f2, st_r.byp_bw);
    st_nxt.byp_out = f;

    // Bus read mux
    unique case (wb_adr_i)
      OFS_CTRL:     cur = {30'h0, st_r.freq_range};
      OFS_ROUTE:    cur = {18'h0, st_r.route_relay, 2'h0, st_r.route_dout};
      OFS_CUR_LO:   cur = {16'h0, st_r.cur_lo};
      OFS_CUR_HI:   cur = {16'h0, st_r.cur_hi};
      OFS_FRQ_LO:   cur = {16'h0, st_r.frq_lo};
      OFS_FRQ_HI:   cur = {16'h0, st_r.frq_hi};
      OFS_FB_LO:    cur = st_r.fb_lo;
      OFS_FB_HI:    cur = st_r.fb_hi;
      OFS_BYP_BW:   cur = {16'h0, st_r.byp_bw};
      OFS_BYP_F1:   cur = {16'h0, st_r.byp_f1};
      OFS_BYP_F2:   cur = {16'h0, st_r.byp_f2};
      OFS_STATUS:   cur = {23'h0, st_r.arm == ST_ARMED, 2'h0, st_r.warn};
      OFS_IRQ_STAT: cur = {26'h0, st_r.irq_stat};
      OFS_IRQ_MASK: cur = {26'h0, st_r.irq_mask};
      // Unmapped offsets read as zero
      default:      cur = '0;
    endcase
    // Partial writes merge into the current value
    mrg = lane_merge(cur, wb_dat_i, wb_sel_i);
    fmax = (st_r.freq_range >= RANGE_WIDE_MIN) ? FRQ_MAX_WIDE : FRQ_MAX_NARROW;

    // Register writes, limits clamped to their legal spans
    if (wr) begin
      unique case (wb_adr_i)
        // Range select; narrowing pulls the upper limit down
        OFS_CTRL: begin
          st_nxt.freq_range = mrg[1:0];
          st_nxt.frq_hi = (mrg[1:0] >= RANGE_WIDE_MIN || st_r.frq_hi <= FRQ_MAX_NARROW)
                        ? st_r.frq_hi : FRQ_MAX_NARROW;
        end
        // Digital output and relay masks
        OFS_ROUTE: begin
          st_nxt.route_dout  = mrg[NWARN-1:0];
          st_nxt.route_relay = mrg[ROUTE_RELAY_LSB +: NWARN];
        end
        // Lower current limit, up to the upper one
        OFS_CUR_LO: begin
          st_nxt.cur_lo = CUR_W'(clamp_u({16'h0, mrg[CUR_W-1:0]}, '0,
                                         {16'h0, st_r.cur_hi}));
        end
        // Upper current limit, from lower limit to ceiling
        OFS_CUR_HI: begin
          st_nxt.cur_hi = CUR_W'(clamp_u({16'h0, mrg[CUR_W-1:0]},
                                         {16'h0, st_r.cur_lo},
                                         {16'h0, CUR_HI_RST}));
        end
        // Lower frequency limit, up to the upper one
        OFS_FRQ_LO: begin
          st_nxt.frq_lo = FREQ_W'(clamp_u({16'h0, mrg[FREQ_W-1:0]}, '0,
                                          {16'h0, st_r.frq_hi}));
        end
        // Upper frequency limit, ceiling set by range
        OFS_FRQ_HI: begin
          st_nxt.frq_hi = FREQ_W'(clamp_u({16'h0, mrg[FREQ_W-1:0]},
                                          {16'h0, st_r.frq_lo},
                                          {16'h0, fmax}));
        end
        // Lower feedback limit, signed order
        OFS_FB_LO: begin
          st_nxt.fb_lo = s2u(clamp_u(s2u(mrg), s2u(FEEDBACK_RANGE_MIN_LIM),
                                     s2u(st_r.fb_hi)));
        end
        // Upper feedback limit, signed order
        OFS_FB_HI: begin
          st_nxt.fb_hi = s2u(clamp_u(s2u(mrg), s2u(st_r.fb_lo),
                                     s2u(FEEDBACK_RANGE_MAX_LIM)));
        end
        // Band width; zero turns bypass off
        OFS_BYP_BW: begin
          st_nxt.byp_bw = FREQ_W'(clamp_u({16'h0, mrg[FREQ_W-1:0]}, '0,
                                          {16'h0, BYP_BW_MAX}));
        end
        // First band centre
        OFS_BYP_F1: begin
          st_nxt.byp_f1 = FREQ_W'(clamp_u({16'h0, mrg[FREQ_W-1:0]}, '0,
                                          {16'h0, BYP_F_MAX}));
        end
        // Second band centre
        OFS_BYP_F2: begin
          st_nxt.byp_f2 = FREQ_W'(clamp_u({16'h0, mrg[FREQ_W-1:0]}, '0,
                                          {16'h0, BYP_F_MAX}));
        end
        // Write one to clear a sticky event
        OFS_IRQ_STAT: clr = mrg[NWARN-1:0] & wb_dat_i[NWARN-1:0];
        // Interrupt enables
        OFS_IRQ_MASK: st_nxt.irq_mask = mrg[NWARN-1:0];
        default: ;
      endcase
    end

    // Sticky events on warning rise; a new event beats the clear
    st_nxt.irq_stat = (st_r.irq_stat & ~clr) | (wnxt & ~st_r.warn);
    // Level interrupt from masked status
    st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_mask);

    // One-cycle acknowledge with registered read data
    st_nxt.ack  = req;
    st_nxt.rdat = (req && !wb_we_i) ? cur : '0;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Defaults after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Fields not named below reset to zero
      st_r             <= '0;
      st_r.arm         <= ST_STOPPED;
      st_r.cur_hi      <= CUR_HI_RST;
      st_r.frq_hi      <= FRQ_HI_RST;
      st_r.fb_lo       <= FB_LO_RST;
      st_r.fb_hi       <= FB_HI_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // All straight from state flops
  assign wb_dat_o      = st_r.rdat;
  assign wb_ack_o      = st_r.ack;
  assign warn_o        = st_r.warn;
  assign digital_out_o = st_r.dout;
  assign relay_o       = st_r.relay;
  assign bypass_freq_o = st_r.byp_out;
  assign irq_o         = st_r.irq;

endmodule // drive_limit_warning_and_bypass
`default_nettype wire

// file: drive_limit_chk.sv
// Purpose: Concurrent checks on the ports of the limit block
// Assumes: One clock, synchronous active-high reset
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module drive_limit_chk
  import drive_limit_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              run_i,
  input wire logic [FREQ_W-1:0] out_freq_i,
  input wire logic [FREQ_W-1:0] ref_freq_i,
  input wire logic [NWARN-1:0]  warn_o,
  input wire logic              digital_out_o,
  input wire logic              relay_o,
  input wire logic              irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");

  // ----------------------------------------
  // Blanking, routing and interrupt
  // ----------------------------------------
  a_stop_blank: assert property (!run_i |=> warn_o == 6'h00)
    else $error("warning while stopped");
  a_start_blank: assert property ($rose(run_i) |=> (warn_o == 6'h00) [*2])
    else $error("warning during start of ramp");
  a_arm_match: assert property (!run_i ##1 (run_i && out_freq_i != ref_freq_i) [*3]
    |=> warn_o == 6'h00)
    else $error("warning before reference reached");
  a_route_quiet: assert property (warn_o == 6'h00 |-> !digital_out_o && !relay_o)
    else $error("routed output without warning");
  a_irq_cause: assert property ($rose(irq_o) |-> wb_ack_o || warn_o != 6'h00)
    else $error("interrupt rose without cause");
endmodule // drive_limit_chk

bind drive_limit_warning_and_bypass drive_limit_chk i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_i(run_i), .out_freq_i(out_freq_i),
  .ref_freq_i(ref_freq_i), .warn_o(warn_o), .digital_out_o(digital_out_o),
  .relay_o(relay_o), .irq_o(irq_o)
);
`default_nettype wire

// file: drive_plant_model.sv
// Purpose: Motor, sensor and command side facing the limit block
// Assumes: Output frequency ramps toward the reference by a fixed step
// Notes:   Operating point is set by the drive task after a clock edge
`timescale 1ns/1ps
`default_nettype none
module drive_plant_model
  import drive_limit_pkg::*;
#(
  parameter logic [FREQ_W-1:0] STEP = 16'h0010
) (
  input  wire logic              clk_i,
  output logic                   run_o,
  output logic [CUR_W-1:0]       current_o,
  output logic [FREQ_W-1:0]      out_freq_o,
  output logic [FREQ_W-1:0]      ref_freq_o,
  output logic [FREQ_W-1:0]      demand_freq_o,
  output logic [FB_W-1:0]        feedback_o
);
  logic [FREQ_W-1:0] tgt;

  // Stopped and idle at time zero
  initial begin
    {run_o, current_o, ref_freq_o, demand_freq_o, feedback_o} = '0;
    out_freq_o = '0;
  end

  // New operating point, applied just after an edge
  task automatic drive(input logic r, input logic [CUR_W-1:0] c,
                       input logic [FREQ_W-1:0] f, input logic [FB_W-1:0] b,
                       input logic [FREQ_W-1:0] d);
    run_o <= r;
    current_o <= c;
    ref_freq_o <= f;
    feedback_o <= b;
    demand_freq_o <= d;
  endtask

  // Shaft speed ramps to the reference, or down to zero when stopped
  assign tgt = run_o ? ref_freq_o : '0;
  always @(posedge clk_i) begin
    if (out_freq_o + STEP < tgt) begin
      out_freq_o <= out_freq_o + STEP;
    end else if (out_freq_o > tgt + STEP) begin
      out_freq_o <= out_freq_o - STEP;
    end else begin
      out_freq_o <= tgt;
    end
  end
endmodule // drive_plant_model
`default_nettype wire

// file: test_drive_limit_warning_and_bypass.sv
// Purpose: Self-checking bench for the limit and bypass block
// Assumes: Classic single Wishbone cycles, 250 MHz clock
// Notes:   Plant model supplies run, current, frequencies and feedback
`timescale 1ns/1ps
`default_nettype none
module test_drive_limit_warning_and_bypass;
  import drive_limit_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, run_i, digital_out_o, relay_o, irq_o;
  logic [15:0] current_i, out_freq_i, ref_freq_i, demand_freq_i, bypass_freq_o;
  logic [31:0] feedback_i;
  logic [5:0]  warn_o;
  int err_count = 0, num_checks = 0;
  logic [7:0]  la [8] = '{OFS_FRQ_HI, OFS_FRQ_LO, OFS_CUR_LO, OFS_CUR_HI, OFS_FB_LO,
                          OFS_FB_HI, OFS_ROUTE, OFS_IRQ_MASK};
  logic [31:0] ld [8] = '{32'h12C, 32'h64, 32'h64, 32'hC8, 32'hFFFFFC18, 32'h3E8,
                          32'h201, 32'h3F};
  logic [15:0] tc [6] = '{16'hFA, 16'h32, 16'h96, 16'h96, 16'h96, 16'h96};
  logic [15:0] tr [6] = '{16'hC8, 16'hC8, 16'h32, 16'h15E, 16'hC8, 16'hC8};
  logic [31:0] tf [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFFF830, 32'h7D0};
  logic [15:0] bd [6] = '{16'h1E0, 16'h208, 16'h190, 16'h3E8, 16'h3C0, 16'h1E0};
  logic [15:0] be [6] = '{16'h1C2, 16'h226, 16'h190, 16'h41A, 16'h3B6, 16'h1E0};

  // 4 ns clock
  always #2 clk_i = ~clk_i;

  drive_limit_warning_and_bypass i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_i(run_i), .current_i(current_i),
    .out_freq_i(out_freq_i), .ref_freq_i(ref_freq_i), .demand_freq_i(demand_freq_i),
    .feedback_i(feedback_i), .warn_o(warn_o), .digital_out_o(digital_out_o),
    .relay_o(relay_o), .bypass_freq_o(bypass_freq_o), .irq_o(irq_o)
  );
  drive_plant_model i_plant (
    .clk_i(clk_i), .run_o(run_i), .current_o(current_i), .out_freq_o(out_freq_i),
    .ref_freq_o(ref_freq_i), .demand_freq_o(demand_freq_i), .feedback_o(feedback_i)
  );

  // ----------------------------------------
  // Compare, bus access, verdict
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    // Only the watchdog ends a missing answer
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    wait_cyc(10000);
    err_count++;
    end_sim();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    wait_cyc(20);
    rst_i <= 1'b0;
    rdc(OFS_CUR_LO, 32'h0, "cur_lo");
    rdc(OFS_CUR_HI, 32'hFFFF, "cur_hi");
    rdc(OFS_FRQ_HI, 32'h528, "frq_hi");
    rdc(OFS_FB_LO, FB_LO_RST, "fb_lo");
    rdc(OFS_FB_HI, FB_HI_RST, "fb_hi");
    rdc(OFS_BYP_BW, 32'h0, "byp_bw");
    rdc(OFS_BYP_F2, 32'h0, "byp_f2");
    rdc(8'h3C, 32'h0, "unmapped");
    $display("test reset_values done");
    wr(OFS_FRQ_HI, 32'h2710);
    rdc(OFS_FRQ_HI, 32'h528, "frq_hi_narrow");
    wr(OFS_CTRL, 32'h2);
    wr(OFS_FRQ_HI, 32'h2710);
    rdc(OFS_FRQ_HI, 32'h2710, "frq_hi_wide");
    wr(OFS_CTRL, 32'h1);
    rdc(OFS_FRQ_HI, 32'h528, "frq_hi_lowered");
    wr(OFS_FB_LO, 32'h80000000);
    rdc(OFS_FB_LO, FEEDBACK_RANGE_MIN_LIM, "fb_lo_min");
    wr(OFS_FB_HI, 32'h7FFFFFFF);
    rdc(OFS_FB_HI, FEEDBACK_RANGE_MAX_LIM, "fb_hi_max");
    wr(OFS_BYP_BW, 32'hFFFF);
    rdc(OFS_BYP_BW, 32'h3E8, "bw_max");
    wr(OFS_BYP_F1, 32'hFFFF);
    rdc(OFS_BYP_F1, 32'h2710, "f1_max");
    $display("test clamping done");
    // Limits kept inside the operating range
    foreach (la[i]) wr(la[i], ld[i]);
    rdc(OFS_ROUTE, 32'h201, "route");
    i_plant.drive(1'b1, 16'h96, 16'hC8, 32'h0, 16'h0);
    wait_cyc(40);
    chk("warn_nominal", warn_o, 32'h0);
    rdc(OFS_STATUS, 32'h100, "status_armed");
    for (int i = 0; i < 6; i++) begin
      i_plant.drive(1'b1, tc[i], tr[i], tf[i], 16'h0);
      wait_cyc(40);
      chk("warn", warn_o, 32'h1 << i);
      chk("digital", digital_out_o, i == 0);
      chk("relay", relay_o, i == 1);
      chk("irq", irq_o, 32'h1);
      i_plant.drive(1'b1, 16'h96, 16'hC8, 32'h0, 16'h0);
      wait_cyc(40);
      wr(OFS_IRQ_STAT, 32'h3F);
      wait_cyc(2);
      chk("irq_clear", irq_o, 32'h0);
    end
    $display("test warnings done");
    wr(OFS_IRQ_MASK, 32'h0);
    i_plant.drive(1'b1, 16'hFA, 16'hC8, 32'h0, 16'h0);
    wait_cyc(4);
    chk("irq_masked", irq_o, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
    wait_cyc(2);
    chk("irq_unmasked", irq_o, 32'h1);
    i_plant.drive(1'b0, 16'hFA, 16'hC8, 32'h0, 16'h0);
    wait_cyc(2);
    chk("warn_stopped", warn_o, 32'h0);
    wait_cyc(40);
    i_plant.drive(1'b1, 16'hFA, 16'hC8, 32'h0, 16'h0);
    wait_cyc(3);
    chk("warn_ramping", warn_o, 32'h0);
    wait_cyc(40);
    chk("warn_rearmed", warn_o, 32'h1);
    $display("test blanking done");
    wr(OFS_BYP_BW, 32'h64);
    wr(OFS_BYP_F1, 32'h1F4);
    wr(OFS_BYP_F2, 32'h3E8);
    for (int i = 0; i < 6; i++) begin
      if (i == 5) wr(OFS_BYP_BW, 32'h0);
      i_plant.drive(1'b1, 16'h96, 16'hC8, 32'h0, bd[i]);
      wait_cyc(3);
      chk("bypass", bypass_freq_o, be[i]);
    end
    $display("test bypass done");
    end_sim();
  end
endmodule // test_drive_limit_warning_and_bypass
`default_nettype wire
